// File: verilog/smsbs_cfg.svh
`ifndef SMSBS_CFG_SVH
`define SMSBS_CFG_SVH
`define SMSBS_OFF_CTRL  4'h0
`define SMSBS_OFF_STAT  4'h4
`define SMSBS_OFF_DATA  4'h8
`define SMSBS_OFF_DIR   4'hc
`define SMSBS_CTRL_RST  8'h00
`define SMSBS_DIR_RST   5'h00
`define SMSBS_DIR_MOSI  0
`define SMSBS_DIR_MISO  1
`define SMSBS_DIR_SCK   2
`define SMSBS_DIR_SS    3
`define SMSBS_DIR_SSVAL 4
`define SMSBS_BITS      4'h8
`define SMSBS_DIV_R0    8'h04
`define SMSBS_DIV_R1    8'h10
`define SMSBS_DIV_R2    8'h40
`define SMSBS_DIV_R3    8'h80
`define SMSBS_RESP_OK   2'h0
`define SMSBS_RESP_ERR  2'h2
`endif

// File: verilog/smsbs_pkg.sv
package smsbs_pkg;
   typedef struct packed {
      logic       xfer_irq_enable;
      logic       serial_enable_bit;
      logic       bit_order_select;
      logic       master_select_bit;
      logic       clk_idle_high;
      logic       sample_trailing;
      logic       rate_select_hi;
      logic       rate_select_lo;
   } smsbs_ctrl_s;

   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss_n;
   } smsbs_pin_s;

   typedef enum logic [0:0] {ST_IDLE, ST_RUN} smsbs_state_e;
endpackage : smsbs_pkg

// File: verilog/smsbs_sync.sv
`timescale 1ns/10ps
module smsbs_sync #(
   parameter int              W    = 4,
   parameter logic [W-1:0]    INIT = '0
) (
   input  wire logic          clock, // system clock
   input  wire logic          nrst,  // async reset, low
   input  wire logic [W-1:0]  din,   // raw pins
   output logic [W-1:0]       dout   // filtered levels
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
      end
      else
      begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a level is taken only once stages two and three agree
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         dout <= INIT;
      else
         for (int i = 0; i < W; i++)
            if (s2_q[i] == s3_q[i])
               dout[i] <= s3_q[i];
   end
endmodule : smsbs_sync

// File: verilog/smsbs_top.sv
`timescale 1ns/10ps
`include "smsbs_cfg.svh"
module smsbs_top
   import smsbs_pkg::*;
(
   input  wire logic        clock,     // 40 MHz system clock
   input  wire logic        nrst,      // async reset, low
   input  wire logic [3:0]  s_awaddr,  // write address
   input  wire logic        s_awvalid, // write address valid
   output logic             s_awready, // write address ready
   input  wire logic [31:0] s_wdata,   // write data
   input  wire logic [3:0]  s_wstrb,   // byte enables
   input  wire logic        s_wvalid,  // write data valid
   output logic             s_wready,  // write data ready
   output logic [1:0]       s_bresp,   // write response
   output logic             s_bvalid,  // write response valid
   input  wire logic        s_bready,  // write response ready
   input  wire logic [3:0]  s_araddr,  // read address
   input  wire logic        s_arvalid, // read address valid
   output logic             s_arready, // read address ready
   output logic [31:0]      s_rdata,   // read data
   output logic [1:0]       s_rresp,   // read response
   output logic             s_rvalid,  // read data valid
   input  wire logic        s_rready,  // read data ready
   input  wire smsbs_pin_s  pin_i,     // pad input levels
   output smsbs_pin_s       pin_o,     // pad output values
   output smsbs_pin_s       pin_oe,    // pad drive enables
   output logic             irq,       // interrupt request
   output logic             wake       // idle wake pulse
);
   smsbs_ctrl_s  serial_control_reg_q;
   smsbs_state_e state_q;
   logic         double_rate_bit_q;
   logic [4:0]   dir_q;
   logic         xfer_done_flag_q;
   logic         write_collision_flag_q;
   logic         arm_q;
   logic [7:0]   sh_q;
   logic [7:0]   rx_q;
   logic         rbit_q;
   logic         pend_q;
   logic [3:0]   scnt_q;
   logic [6:0]   div_q;
   logic         sck_q;
   logic         sck_prev_q;
   logic         wake_q;
   logic         aw_got_q;
   logic         w_got_q;
   logic [3:0]   waddr_q;
   logic [7:0]   wdata_q;
   logic         wstrb_q;
   smsbs_pin_s   pin_f;
   smsbs_ctrl_s  ctl;
   logic en_m, en_s, wr_go, rd_go, data_wr, data_acc, stat_rd, clr;
   logic tick, m_edge, s_edge, lead, sample, setup, last, shift_ev;
   logic done_ev, mfault, abort, start_m, collide, load, in_bit;
   logic shift_bit, out_bit;
   logic [6:0] half_m1;

   function automatic logic [6:0] half_period(input logic [1:0] r,
                                              input logic dbl);
      logic [7:0] d;
      case (r)
         2'h0:    d = `SMSBS_DIV_R0;
         2'h1:    d = `SMSBS_DIV_R1;
         2'h2:    d = `SMSBS_DIV_R2;
         default: d = `SMSBS_DIV_R3;
      endcase
      // half a clock period; double speed halves it again
      return dbl ? {1'b0, d[7:2]} : d[7:1];
   endfunction : half_period

   function automatic logic [7:0] shift_in(input logic [7:0] s,
                                           input logic b,
                                           input logic lsb);
      return lsb ? {b, s[7:1]} : {s[6:0], b};
   endfunction : shift_in

   smsbs_sync #(.W(4), .INIT(4'h1)) u_sync (
      .clock (clock),
      .nrst  (nrst),
      .din   (pin_i),
      .dout  (pin_f)
   );

   assign ctl = serial_control_reg_q;
   assign en_m = ctl.serial_enable_bit & ctl.master_select_bit;
   assign en_s = ctl.serial_enable_bit & ~ctl.master_select_bit;

   // register bus
   assign s_awready = ~aw_got_q & ~s_bvalid;
   assign s_wready  = ~w_got_q & ~s_bvalid;
   assign s_arready = ~s_rvalid;
   assign wr_go     = aw_got_q & w_got_q;
   assign rd_go     = s_arvalid & s_arready;
   assign data_wr   = wr_go & wstrb_q & (waddr_q == `SMSBS_OFF_DATA);
   assign stat_rd   = rd_go & (s_araddr == `SMSBS_OFF_STAT);
   assign data_acc  = data_wr | (rd_go & (s_araddr == `SMSBS_OFF_DATA));
   assign clr       = arm_q & data_acc;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         aw_got_q <= 1'b0;
         w_got_q  <= 1'b0;
         waddr_q  <= 4'h0;
         wdata_q  <= 8'h00;
         wstrb_q  <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp  <= `SMSBS_RESP_OK;
      end
      else
      begin
         if (s_awvalid & s_awready)
         begin
            aw_got_q <= 1'b1;
            waddr_q  <= s_awaddr;
         end
         if (s_wvalid & s_wready)
         begin
            w_got_q <= 1'b1;
            wdata_q <= s_wdata[7:0];
            wstrb_q <= s_wstrb[0];
         end
         if (wr_go)
         begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp  <= (waddr_q[1:0] == 2'h0) ? `SMSBS_RESP_OK
                                               : `SMSBS_RESP_ERR;
         end
         else if (s_bready)
            s_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         s_rvalid <= 1'b0;
         s_rdata  <= 32'h0;
         s_rresp  <= `SMSBS_RESP_OK;
      end
      else if (rd_go)
      begin
         s_rvalid <= 1'b1;
         s_rresp  <= `SMSBS_RESP_OK;
         case (s_araddr)
            `SMSBS_OFF_CTRL: s_rdata <= {24'h0, serial_control_reg_q};
            `SMSBS_OFF_STAT: s_rdata <= {24'h0, xfer_done_flag_q,
                                         write_collision_flag_q, 5'h00,
                                         double_rate_bit_q};
            `SMSBS_OFF_DATA: s_rdata <= {24'h0, rx_q};
            `SMSBS_OFF_DIR:  s_rdata <= {27'h0, dir_q};
            default:
            begin
               s_rdata <= 32'h0;
               s_rresp <= `SMSBS_RESP_ERR;
            end
         endcase
      end
      else if (s_rready)
         s_rvalid <= 1'b0;
   end

   // configuration; a master fault overrides a written master select bit in the same cycle
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         serial_control_reg_q <= smsbs_ctrl_s'(`SMSBS_CTRL_RST);
         double_rate_bit_q    <= 1'b0;
         dir_q                <= `SMSBS_DIR_RST;
      end
      else
      begin
         if (wr_go & wstrb_q)
            case (waddr_q)
               `SMSBS_OFF_CTRL: serial_control_reg_q <= wdata_q;
               `SMSBS_OFF_STAT: double_rate_bit_q <= wdata_q[0];
               `SMSBS_OFF_DIR:  dir_q <= wdata_q[4:0];
               default:         dir_q <= dir_q;
            endcase
         if (mfault)
            serial_control_reg_q.master_select_bit <= 1'b0;
      end
   end

   // master clock generator
   assign half_m1 = half_period({ctl.rate_select_hi, ctl.rate_select_lo},
                                double_rate_bit_q) - 7'h1;
   assign tick    = en_m & (state_q == ST_RUN) & (div_q == half_m1);
   assign m_edge  = tick;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         div_q <= 7'h0;
      else if (~en_m | (state_q != ST_RUN) | tick)
         div_q <= 7'h0;
      else
         div_q <= div_q + 7'h1;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         sck_q <= 1'b0;
      else if (~en_m | (state_q != ST_RUN))
         sck_q <= ctl.clk_idle_high;
      else if (m_edge)
         sck_q <= ~sck_q;
   end

   // slave edges come from the filtered pin; the remote clock must stay
   // at or below a quarter of the system clock or edges merge
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         sck_prev_q <= 1'b0;
      else
         sck_prev_q <= pin_f.sck;
   end
   assign s_edge = en_s & ~pin_f.ss_n & (pin_f.sck != sck_prev_q);

   // leading edge leaves the idle level; phase picks the sampling edge
   assign lead   = ctl.master_select_bit ? (sck_q == ctl.clk_idle_high)
                                         : (sck_prev_q == ctl.clk_idle_high);
   assign sample = (m_edge | s_edge) & (lead ^ ctl.sample_trailing);
   assign setup  = (m_edge | s_edge) & ~(lead ^ ctl.sample_trailing);
   assign in_bit = ctl.master_select_bit ? pin_f.miso : pin_f.mosi;
   // with trailing-edge sampling no setup edge follows the last sample
   assign last   = sample & ctl.sample_trailing
                   & (scnt_q == `SMSBS_BITS - 4'h1);
   assign shift_ev  = (setup & pend_q) | last;
   assign shift_bit = last ? in_bit : rbit_q;
   assign done_ev   = last | (setup & pend_q & (scnt_q == `SMSBS_BITS));
   assign out_bit   = ctl.bit_order_select ? sh_q[0] : sh_q[7];

   assign mfault  = en_m & ~dir_q[`SMSBS_DIR_SS] & ~pin_f.ss_n;
   assign abort   = mfault | ~ctl.serial_enable_bit
                    | (en_s & pin_f.ss_n);
   assign start_m = data_wr & en_m & (state_q == ST_IDLE) & ~mfault;
   assign collide = data_wr & (state_q == ST_RUN);
   assign load    = data_wr & (state_q == ST_IDLE);

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= ST_IDLE;
         scnt_q  <= 4'h0;
         pend_q  <= 1'b0;
         rbit_q  <= 1'b0;
      end
      else if (abort)
      begin
         // partial bits are dropped; the slave counter resynchronises
         state_q <= ST_IDLE;
         scnt_q  <= 4'h0;
         pend_q  <= 1'b0;
      end
      else
      begin
         if (sample)
         begin
            rbit_q <= in_bit;
            pend_q <= 1'b1;
            scnt_q <= scnt_q + 4'h1;
         end
         if (shift_ev)
            pend_q <= 1'b0;
         if (done_ev)
         begin
            state_q <= ST_IDLE;
            scnt_q  <= 4'h0;
         end
         else if (start_m | s_edge)
            state_q <= ST_RUN;
      end
   end

   // single transmit buffer: the shifter itself holds the outgoing byte
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         sh_q <= 8'h00;
      else if (shift_ev)
         sh_q <= shift_in(sh_q, shift_bit, ctl.bit_order_select);
      else if (load)
         sh_q <= wdata_q;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         rx_q <= 8'h00;
      else if (done_ev)
         rx_q <= shift_in(sh_q, shift_bit, ctl.bit_order_select);
   end

   // flags: status read arms, data access clears, a new event wins
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         xfer_done_flag_q       <= 1'b0;
         write_collision_flag_q <= 1'b0;
         arm_q                  <= 1'b0;
         wake_q                 <= 1'b0;
      end
      else
      begin
         if (done_ev | mfault)
            xfer_done_flag_q <= 1'b1;
         else if (clr)
            xfer_done_flag_q <= 1'b0;
         if (collide)
            write_collision_flag_q <= 1'b1;
         else if (clr)
            write_collision_flag_q <= 1'b0;
         if (stat_rd & (xfer_done_flag_q | write_collision_flag_q))
            arm_q <= 1'b1;
         else if (clr)
            arm_q <= 1'b0;
         wake_q <= done_ev | mfault;
      end
   end

   assign irq  = xfer_done_flag_q & ctl.xfer_irq_enable;
   assign wake = wake_q;

   // pad control; select is left to software in master role
   always_comb
   begin
      pin_o.sck  = sck_q;
      pin_o.mosi = out_bit;
      pin_o.miso = out_bit;
      pin_o.ss_n = dir_q[`SMSBS_DIR_SSVAL];
      pin_oe.sck  = dir_q[`SMSBS_DIR_SCK];
      pin_oe.mosi = dir_q[`SMSBS_DIR_MOSI];
      pin_oe.miso = dir_q[`SMSBS_DIR_MISO];
      pin_oe.ss_n = dir_q[`SMSBS_DIR_SS];
      if (en_m)
         pin_oe.miso = 1'b0;
      else if (en_s)
      begin
         pin_oe.sck  = 1'b0;
         pin_oe.mosi = 1'b0;
         pin_oe.ss_n = 1'b0;
         pin_oe.miso = dir_q[`SMSBS_DIR_MISO] & ~pin_f.ss_n;
      end
   end

   property p_start;
      @(posedge clock) disable iff (!nrst)
      start_m |=> state_q == ST_RUN;
   endproperty
   a_start: assert property (p_start)
      else $error("master start did not run");

   property p_sck_idle;
      @(posedge clock) disable iff (!nrst)
      done_ev & en_m & ~abort |=> sck_q == ctl.clk_idle_high;
   endproperty
   a_sck_idle: assert property (p_sck_idle)
      else $error("clock not idle after byte");

   property p_irq;
      @(posedge clock) disable iff (!nrst)
      done_ev & ctl.xfer_irq_enable & ~abort |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("no interrupt after completion");

   property p_miso_tri;
      @(posedge clock) disable iff (!nrst)
      en_s & pin_f.ss_n |-> ~pin_oe.miso ##1 scnt_q == 4'h0;
   endproperty
   a_miso_tri: assert property (p_miso_tri)
      else $error("slave active while unselected");

   property p_done;
      @(posedge clock) disable iff (!nrst)
      done_ev |=> xfer_done_flag_q && state_q == ST_IDLE;
   endproperty
   a_done: assert property (p_done)
      else $error("done flag not set");

   property p_write_collision_flag;
      @(posedge clock) disable iff (!nrst)
      collide |=> write_collision_flag_q;
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag)
      else $error("collision not flagged");

   property p_keep;
      @(posedge clock) disable iff (!nrst)
      collide & ~shift_ev |=> sh_q == $past(sh_q);
   endproperty
   a_keep: assert property (p_keep)
      else $error("colliding write disturbed shifter");

   property p_fault;
      @(posedge clock) disable iff (!nrst)
      mfault |=> ~ctl.master_select_bit && xfer_done_flag_q;
   endproperty
   a_fault: assert property (p_fault)
      else $error("select fault not handled");

   property p_dir;
      @(posedge clock) disable iff (!nrst)
      en_s |-> ~pin_oe.sck && ~pin_oe.mosi && ~pin_oe.ss_n;
   endproperty
   a_dir: assert property (p_dir)
      else $error("slave pin direction not forced");

   property p_rate;
      @(posedge clock) disable iff (!nrst)
      start_m & ~double_rate_bit_q & ~ctl.rate_select_hi
      & ~ctl.rate_select_lo |=> ~m_edge ##1 m_edge;
   endproperty
   a_rate: assert property (p_rate)
      else $error("fastest rate edge misplaced");
endmodule : smsbs_top

// File: verification/smsbs_peer.sv
`timescale 1ns/10ps
module smsbs_peer (
   input  wire logic       sck,     // serial clock from the master
   input  wire logic       mosi,    // master-out data
   input  wire logic       ss_n,    // select, active low
   input  wire logic       cpol,    // idle clock level
   input  wire logic       cpha,    // 1: sample on trailing edge
   input  wire logic       lsb,     // 1: lsb first
   input  wire logic [7:0] tx_byte, // byte to send next
   output logic            miso,    // master-in data
   output logic [7:0]      rx_byte  // last whole byte taken in
);
   logic [7:0] tx_q    = 8'h00;
   logic [7:0] sh_q    = 8'h00;
   logic [3:0] setup_q = 4'h0;
   logic [2:0] nrx_q   = 3'h0;
   logic       held_q  = 1'b0;
   logic       mosi_h  = 1'b0;
   logic [2:0] idx;
   logic       drv;

   // a bit launched on the sampling edge itself is still seen as the old
   // one, as a real input with some hold time would see it
   always @(mosi)
      mosi_h <= #1 mosi;

   // a falling select restarts byte framing
   always @(negedge ss_n)
   begin
      tx_q    = tx_byte;
      setup_q = 4'h0;
      nrx_q   = 3'h0;
   end

   always @(sck)
   begin
      if (!ss_n && ((sck != cpol) ^ cpha))
      begin
         sh_q = lsb ? {mosi_h, sh_q[7:1]} : {sh_q[6:0], mosi_h};
         nrx_q = nrx_q + 3'h1;
         if (nrx_q == 3'h0)
         begin
            rx_byte = sh_q;
            tx_q    = tx_byte;
         end
      end
      else if (!ss_n)
         setup_q = setup_q + 4'h1;
   end

   assign idx = setup_q[2:0] - {2'h0, cpha};
   assign drv = lsb ? tx_q[idx] : tx_q[3'h7 - idx];

   always @(drv or ss_n)
      if (!ss_n)
         held_q = drv;

   // released line shows the opposite of its last bit, never a stale copy
   assign miso = ss_n ? ~held_q : drv;
endmodule : smsbs_peer

// File: verification/tb.sv
`timescale 1ns/10ps
`include "smsbs_cfg.svh"
module tb
   import smsbs_pkg::*;
;
   logic        clock     = 1'b0;
   logic        nrst      = 1'b0;
   logic [3:0]  s_awaddr  = 4'h0;
   logic [3:0]  s_araddr  = 4'h0;
   logic        s_awvalid = 1'b0;
   logic        s_wvalid  = 1'b0;
   logic        s_bready  = 1'b0;
   logic        s_arvalid = 1'b0;
   logic        s_rready  = 1'b0;
   logic [31:0] s_wdata   = 32'h0;
   logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic        irq, wake, peer_miso;
   logic [1:0]  s_bresp, s_rresp;
   logic [31:0] s_rdata;
   smsbs_pin_s  pin_w, pin_o, pin_oe;
   logic        tb_sck    = 1'b0;
   logic        tb_mosi   = 1'b0;
   logic        tb_ss_n   = 1'b1;
   smsbs_ctrl_s p_cfg     = 8'h00;
   logic [7:0]  p_tx      = 8'h00;
   logic [7:0]  p_rx, got;
   logic        sck_prev  = 1'b0;
   logic [31:0] rnd       = 32'hf921;
   logic [31:0] rd_d;
   logic [1:0]  rd_r;
   int          run = 0, half_seen = 0, err_total = 0, n_compared = 0, k;

   always #12.5 clock = ~clock;

   // each wire is driven by whichever party has its enable up
   assign pin_w = {pin_oe.sck  ? pin_o.sck  : tb_sck,
                   pin_oe.mosi ? pin_o.mosi : tb_mosi,
                   pin_oe.miso ? pin_o.miso : peer_miso,
                   pin_oe.ss_n ? pin_o.ss_n : tb_ss_n};

   smsbs_top i_dut (
      .clock(clock), .nrst(nrst), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
      .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready), .pin_i(pin_w), .pin_o(pin_o),
      .pin_oe(pin_oe), .irq(irq), .wake(wake));

   smsbs_peer i_peer (
      .sck(pin_w.sck), .mosi(pin_w.mosi), .ss_n(pin_w.ss_n),
      .cpol(p_cfg.clk_idle_high), .cpha(p_cfg.sample_trailing),
      .lsb(p_cfg.bit_order_select), .tx_byte(p_tx), .miso(peer_miso),
      .rx_byte(p_rx));

   // length of the last steady stretch of the serial clock, in cycles
   always @(posedge clock)
   begin
      sck_prev <= pin_o.sck;
      if (pin_o.sck !== sck_prev)
      begin
         half_seen <= run;
         run       <= 1;
      end
      else
         run <= run + 1;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic int exp_half(input logic [1:0] r, input logic dbl);
      int d;
      d = (r == 2'h0) ? 4 : (r == 2'h1) ? 16 : (r == 2'h2) ? 64 : 128;
      return dbl ? d / 4 : d / 2;
   endfunction : exp_half

   task automatic test_done;
      if (err_total == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %0t: got %h, want %h", $time, seen, exp);
      end
   endtask : check

   task automatic tmo(input int t);
      if (t > 4000)
      begin
         err_total++;
         $display("Error %0t: wait timed out", $time);
         test_done();
      end
   endtask : tmo

   task automatic axi_wr(input logic [3:0] a, input logic [7:0] d);
      int   t;
      logic aw_p, w_p, b_p;
      t    = 0;
      aw_p = 1'b1;
      w_p  = 1'b1;
      b_p  = 1'b1;
      @(posedge clock);
      s_awaddr  <= a;
      s_awvalid <= 1'b1;
      s_wdata   <= {24'h0, d};
      s_wvalid  <= 1'b1;
      s_bready  <= 1'b1;
      while (aw_p || w_p || b_p)
      begin
         @(posedge clock);
         if (s_awvalid && s_awready)
         begin
            aw_p = 1'b0;
            s_awvalid <= 1'b0;
         end
         if (s_wvalid && s_wready)
         begin
            w_p = 1'b0;
            s_wvalid <= 1'b0;
         end
         if (s_bvalid && s_bready)
         begin
            b_p = 1'b0;
            s_bready <= 1'b0;
            check(s_bresp, `SMSBS_RESP_OK);
         end
         t++;
         tmo(t);
      end
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a);
      int   t;
      logic r_p;
      t   = 0;
      r_p = 1'b1;
      @(posedge clock);
      s_araddr  <= a;
      s_arvalid <= 1'b1;
      s_rready  <= 1'b1;
      while (r_p)
      begin
         @(posedge clock);
         if (s_arvalid && s_arready)
            s_arvalid <= 1'b0;
         if (s_rvalid && s_rready)
         begin
            r_p  = 1'b0;
            rd_d = s_rdata;
            rd_r = s_rresp;
            s_rready <= 1'b0;
         end
         t++;
         tmo(t);
      end
   endtask : axi_rd

   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      axi_rd(a);
      check(rd_d, exp);
   endtask : rdc

   task automatic wait_wake;
      int t;
      t = 0;
      do
      begin
         @(posedge clock);
         t++;
         tmo(t);
      end
      while (wake !== 1'b1);
   endtask : wait_wake

   // bench as remote master, mode 0, clock high 8 cycles and low 9
   task automatic spi_byte(input logic [7:0] o, input logic lsb);
      int i;
      for (i = 0; i < 8; i++)
      begin
         @(posedge clock);
         tb_mosi <= lsb ? o[i] : o[7-i];
         repeat (8) @(posedge clock);
         got[lsb ? i : 7-i] = pin_w.miso;
         tb_sck <= 1'b1;
         repeat (8) @(posedge clock);
         tb_sck <= 1'b0;
      end
   endtask : spi_byte

   task automatic master_xfer(input logic [1:0] rt, input logic dbl,
                              input logic collide);
      smsbs_ctrl_s c;
      logic [7:0]  t1, t2, b2;
      logic        dchk, col;
      rnd  = lfsr(rnd);
      c    = {rnd[0], 1'b1, rnd[1], 1'b1, rnd[2], rnd[3], rt};
      t1   = rnd[15:8];
      t2   = rnd[23:16];
      rnd  = lfsr(rnd);
      b2   = rnd[7:0];
      // the core's filtered miso input lags, so data is judged at slow rates
      dchk = exp_half(rt, dbl) >= 8;
      col  = collide & dchk;
      axi_wr(`SMSBS_OFF_STAT, {7'h0, dbl});
      axi_wr(`SMSBS_OFF_CTRL, c);
      axi_wr(`SMSBS_OFF_DIR, 8'h1f);
      p_cfg <= c;
      p_tx  <= rnd[15:8];
      axi_wr(`SMSBS_OFF_DIR, 8'h0f);
      p_tx <= b2;
      axi_wr(`SMSBS_OFF_DATA, t1);
      if (col)
         axi_wr(`SMSBS_OFF_DATA, ~t1);
      wait_wake();
      check(half_seen, exp_half(rt, dbl));
      check(pin_o.sck, c.clk_idle_high);
      check(irq, c.xfer_irq_enable);
      check(pin_oe.miso, 1'b0);
      rdc(`SMSBS_OFF_STAT, {24'h0, 1'b1, col, 5'h0, dbl});
      if (dchk)
         check(p_rx, t1);
      axi_wr(`SMSBS_OFF_DATA, t2);
      wait_wake();
      rdc(`SMSBS_OFF_STAT, {24'h0, 1'b1, 6'h0, dbl});
      axi_rd(`SMSBS_OFF_DATA);
      if (dchk)
         check({p_rx, rd_d[7:0]}, {t2, rnd[7:0]});
      rdc(`SMSBS_OFF_STAT, {31'h0, dbl});
      axi_wr(`SMSBS_OFF_DIR, 8'h1f);
   endtask : master_xfer

   initial
   begin
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      rdc(`SMSBS_OFF_CTRL, 32'h0);
      rdc(`SMSBS_OFF_STAT, 32'h0);
      rdc(`SMSBS_OFF_DIR, 32'h0);
      axi_rd(4'h2);
      check(rd_r, `SMSBS_RESP_ERR);
      for (k = 0; k < 8; k++)
         master_xfer(k[1:0], k[2], k[0]);
      axi_wr(`SMSBS_OFF_STAT, 8'h00);
      axi_wr(`SMSBS_OFF_DIR, 8'h07);
      axi_wr(`SMSBS_OFF_CTRL, 8'hd0);
      tb_ss_n <= 1'b0;
      wait_wake();
      rdc(`SMSBS_OFF_CTRL, 32'hc0);
      check({irq, pin_oe.sck}, 2'b10);
      rdc(`SMSBS_OFF_STAT, 32'h80);
      axi_rd(`SMSBS_OFF_DATA);
      tb_ss_n <= 1'b1;
      rnd = lfsr(rnd);
      axi_wr(`SMSBS_OFF_CTRL, {2'h3, rnd[0], 5'h0});
      axi_wr(`SMSBS_OFF_DIR, 8'h1f);
      check(pin_oe, 4'h0);
      axi_wr(`SMSBS_OFF_DATA, 8'h80);
      spi_byte(8'h55, rnd[0]);
      rdc(`SMSBS_OFF_STAT, 32'h0);
      tb_ss_n <= 1'b0;
      repeat (8) @(posedge clock);
      check(pin_oe, 4'h2);
      spi_byte(rnd[15:8], rnd[0]);
      check(got, 8'h80);
      repeat (12) @(posedge clock);
      check(irq, 1'b1);
      axi_wr(`SMSBS_OFF_DATA, 8'h01);
      spi_byte(rnd[23:16], rnd[0]);
      check(got, 8'h01);
      repeat (12) @(posedge clock);
      rdc(`SMSBS_OFF_STAT, 32'h80);
      rdc(`SMSBS_OFF_DATA, {24'h0, rnd[23:16]});
      tb_ss_n <= 1'b1;
      test_done();
   end
endmodule : tb
